// ---- rtl/bfbr_exec.sv ----
// Execution unit for bitfield, widening and jump operations, one operation per cycle.
// Assumes operands, flags and block start requests arrive from decode each cycle; the conditional block state is tracked here.
`timescale 1ns/1ps
module bfbr_exec (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic op_valid_in,
  input wire bfbr_pkg::bfbr_op_t op_in,
  input wire logic [3:0] cond_in,
  input wire logic block_start_in,
  input wire logic [2:0] block_len_in,
  input wire logic [3:0] block_then_mask_in,
  input wire logic [3:0] flags_in,
  input wire logic [31:0] dest_val_in,
  input wire logic [31:0] first_src_in,
  input wire logic [31:0] operand_in,
  input wire logic [4:0] field_low_pos_in,
  input wire logic [5:0] field_width_in,
  input wire logic [1:0] rotate_sel_in,
  input wire logic [31:0] pc_in,
  input wire logic [31:0] rel_offset_in,
  output logic wr_en_out,
  output logic [31:0] wr_data_out,
  output logic ret_wr_en_out,
  output logic [31:0] ret_data_out,
  output logic [3:0] ret_idx_out,
  output logic pc_load_out,
  output logic [31:0] pc_target_out,
  output logic misuse_fault_out,
  output logic range_err_out,
  output logic [3:0] flags_out
);
  // Mask of width ones starting at position; width zero gives an empty mask.
  function automatic logic [31:0] field_mask(input logic [4:0] pos, input logic [5:0] wid);
    logic [32:0] ones;
    // A lone bit at position wid, less one, leaves wid low ones; wid of 32 fills the word.
    ones = (33'h1_0000_0000 >> (6'h20 - wid)) - 33'h0_0000_0001;
    field_mask = ones[31:0] << pos;
  endfunction

  // Evaluate a four bit condition code against the N Z C V flags.
  function automatic logic cond_pass(input logic [3:0] c, input logic [3:0] f);
    logic base;
    base = 1'b1;
    case (c[3:1])
      3'h0: base = f[2];
      3'h1: base = f[1];
      3'h2: base = f[3];
      3'h3: base = f[0];
      3'h4: base = f[1] & ~f[2];
      3'h5: base = f[3] == f[0];
      3'h6: base = ~f[2] & (f[3] == f[0]);
      default: base = 1'b1;
    endcase
    cond_pass = (c == bfbr_pkg::COND_ALWAYS || c == 4'hF) ? 1'b1 : base ^ c[0];
  endfunction

  // Conditional block tracking: condition, remaining count and then/else pattern.
  logic [3:0] blk_cond_q, blk_cond_d;
  logic [2:0] blk_left_q, blk_left_d;
  logic [3:0] blk_mask_q, blk_mask_d;
  wire logic in_block = blk_left_q != 3'h0;
  // Next block state; a start reloads it, else each valid operation inside a block consumes one slot, up to four.
  always_comb begin
    blk_cond_d = blk_cond_q;
    blk_left_d = blk_left_q;
    blk_mask_d = blk_mask_q;
    if (block_start_in) begin
      blk_cond_d = cond_in;
      blk_left_d = (block_len_in > bfbr_pkg::BLOCK_MAX) ? bfbr_pkg::BLOCK_MAX : block_len_in;
      blk_mask_d = block_then_mask_in;
    end else if (op_valid_in && in_block) begin
      blk_left_d = blk_left_q - 3'h1;
      blk_mask_d = {1'b0, blk_mask_q[3:1]};
    end
  end

  // Inside a block the slot's condition is the block condition or its inverse.
  wire logic [3:0] eff_cond = in_block ? {blk_cond_q[3:1], blk_cond_q[0] ^ ~blk_mask_q[0]}
                                      : cond_in;
  wire logic pass = cond_pass(eff_cond, flags_in);

  // Bitfield datapath.
  wire logic [31:0] fmask = field_mask(field_low_pos_in, field_width_in);
  wire logic [31:0] clear_res = dest_val_in & ~fmask;
  wire logic [31:0] ins_res = clear_res | ((first_src_in << field_low_pos_in) & fmask);
  wire logic [31:0] ext_raw = (first_src_in & fmask) >> field_low_pos_in;
  wire logic [5:0] top_pos = 6'(field_low_pos_in) + field_width_in - 6'h1;
  wire logic ext_sign = first_src_in[top_pos[4:0]];
  wire logic [31:0] wmask = field_mask(5'h00, field_width_in);
  wire logic [31:0] sext_res = ext_raw | ({32{ext_sign}} & ~wmask);
  wire logic [31:0] uext_res = ext_raw;

  // Widening datapath: rotate first, then take the byte or halfword.
  wire logic [4:0] rot_amt = 5'(rotate_sel_in) * bfbr_pkg::ROT_STEP_BITS;
  wire logic [31:0] rot_val = (operand_in >> rot_amt) | (operand_in << (6'h20 - 6'(rot_amt)));
  wire logic [31:0] sb_res = {{24{rot_val[7]}}, rot_val[7:0]};
  wire logic [31:0] zb_res = {24'h00_0000, rot_val[7:0]};
  wire logic [31:0] sh_res = {{16{rot_val[15]}}, rot_val[15:0]};
  wire logic [31:0] zh_res = {16'h0000, rot_val[15:0]};

  // Jump targets and checks.
  wire logic [31:0] reg_target = {first_src_in[31:1], 1'b0};
  wire logic tgt_bit0_clear = ~first_src_in[0];
  wire logic signed [31:0] soff = rel_offset_in;
  wire logic far_ok = (soff >= -bfbr_pkg::RANGE_FAR) && (soff < bfbr_pkg::RANGE_FAR);
  wire logic near_ok = (soff >= -bfbr_pkg::RANGE_NEAR) && (soff < bfbr_pkg::RANGE_NEAR);
  wire logic is_zero = first_src_in == 32'h0000_0000;
  wire logic [31:0] next_addr = pc_in + bfbr_pkg::INSTR_STEP;
  wire logic [31:0] rel_target = pc_in + rel_offset_in;

  // Decoded result for this cycle.
  logic wr_d, ret_d, pcl_d, flt_d, rng_d;
  logic [31:0] wdata_d, pct_d;
  always_comb begin
    wr_d = 1'b0;
    ret_d = 1'b0;
    pcl_d = 1'b0;
    flt_d = 1'b0;
    rng_d = 1'b0;
    wdata_d = 32'h0000_0000;
    pct_d = 32'h0000_0000;
    if (op_valid_in && pass) begin
      unique case (op_in)
        bfbr_pkg::BFBR_FIELD_CLEAR: begin wr_d = 1'b1; wdata_d = clear_res; end
        bfbr_pkg::BFBR_FIELD_INSERT: begin wr_d = 1'b1; wdata_d = ins_res; end
        bfbr_pkg::BFBR_SIGNED_EXTRACT: begin wr_d = 1'b1; wdata_d = sext_res; end
        bfbr_pkg::BFBR_UNSIGNED_EXTRACT: begin wr_d = 1'b1; wdata_d = uext_res; end
        bfbr_pkg::BFBR_SIGN_WIDEN_BYTE: begin wr_d = 1'b1; wdata_d = sb_res; end
        bfbr_pkg::BFBR_ZERO_WIDEN_BYTE: begin wr_d = 1'b1; wdata_d = zb_res; end
        bfbr_pkg::BFBR_SIGN_WIDEN_HALF: begin wr_d = 1'b1; wdata_d = sh_res; end
        bfbr_pkg::BFBR_ZERO_WIDEN_HALF: begin wr_d = 1'b1; wdata_d = zh_res; end
        bfbr_pkg::BFBR_REL_JUMP: begin
          // Outside a block a conditional jump has the short reach.
          if ((in_block || cond_in == bfbr_pkg::COND_ALWAYS) ? far_ok : near_ok) begin
            pcl_d = 1'b1;
            pct_d = rel_target;
          end else begin
            rng_d = 1'b1;
          end
        end
        bfbr_pkg::BFBR_CALL_REL_JUMP: begin
          if (far_ok) begin
            pcl_d = 1'b1;
            pct_d = rel_target;
            ret_d = 1'b1;
          end else begin
            rng_d = 1'b1;
          end
        end
        bfbr_pkg::BFBR_REG_JUMP, bfbr_pkg::BFBR_REG_CALL: begin
          if (tgt_bit0_clear) begin
            flt_d = 1'b1;
          end else begin
            pcl_d = 1'b1;
            pct_d = reg_target;
            ret_d = op_in == bfbr_pkg::BFBR_REG_CALL;
          end
        end
        bfbr_pkg::BFBR_ZERO_TEST_JUMP: begin pcl_d = is_zero; pct_d = rel_target; end
        bfbr_pkg::BFBR_NONZERO_TEST_JUMP: begin pcl_d = ~is_zero; pct_d = rel_target; end
        default: begin end
      endcase
    end
  end

  // Output and block state registers; flags pass through unchanged for every op.
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      blk_cond_q <= 4'h0;
      blk_left_q <= 3'h0;
      blk_mask_q <= 4'h0;
      wr_en_out <= 1'b0;
      wr_data_out <= 32'h0000_0000;
      ret_wr_en_out <= 1'b0;
      ret_data_out <= 32'h0000_0000;
      ret_idx_out <= 4'h0;
      pc_load_out <= 1'b0;
      pc_target_out <= 32'h0000_0000;
      misuse_fault_out <= 1'b0;
      range_err_out <= 1'b0;
      flags_out <= 4'h0;
    end else begin
      blk_cond_q <= blk_cond_d;
      blk_left_q <= blk_left_d;
      blk_mask_q <= blk_mask_d;
      wr_en_out <= wr_d;
      wr_data_out <= wdata_d;
      ret_wr_en_out <= ret_d;
      ret_data_out <= next_addr;
      ret_idx_out <= bfbr_pkg::RETURN_ADDR_IDX;
      pc_load_out <= pcl_d;
      pc_target_out <= pct_d;
      misuse_fault_out <= flt_d;
      range_err_out <= rng_d;
      flags_out <= flags_in;
    end
  end

  chk_flags_kept: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    rst_n_in |=> flags_out == $past(flags_in)) else $error("flags changed");
  chk_fault_no_jump: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    misuse_fault_out |-> !pc_load_out && !ret_wr_en_out) else $error("fault with jump");
  chk_target_even: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (op_valid_in && pass && op_in == bfbr_pkg::BFBR_REG_JUMP && first_src_in[0])
    |=> pc_load_out && !pc_target_out[0]) else $error("odd jump target");
  chk_call_link: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    ret_wr_en_out |-> pc_load_out && ret_idx_out == bfbr_pkg::RETURN_ADDR_IDX)
    else $error("link without jump");
  chk_zero_jump: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (op_valid_in && pass && op_in == bfbr_pkg::BFBR_ZERO_TEST_JUMP)
    |=> pc_load_out == $past(is_zero)) else $error("zero test wrong");
  chk_nonzero_jump: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (op_valid_in && pass && op_in == bfbr_pkg::BFBR_NONZERO_TEST_JUMP)
    |=> pc_load_out != $past(is_zero)) else $error("nonzero test wrong");
  chk_fail_quiet: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (op_valid_in && !pass) |=> !wr_en_out && !pc_load_out && !ret_wr_en_out)
    else $error("update on failed condition");
  chk_block_len: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    blk_left_q <= 3'h4) else $error("block too long");
  chk_clear_field: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (op_valid_in && pass && op_in == bfbr_pkg::BFBR_FIELD_CLEAR)
    |=> (wr_data_out & $past(fmask)) == 32'h0000_0000) else $error("field not cleared");
endmodule

// ---- rtl/bfbr_pkg.sv ----
// Package holding operation codes, field limits and register numbers of the bitfield and
// jump execution unit.
// Assumes the decode stage delivers one decoded operation per cycle with operands read.
package bfbr_pkg;
  // Decoded operations handled by the unit.
  typedef enum logic [3:0] {
    BFBR_NOP, BFBR_FIELD_CLEAR, BFBR_FIELD_INSERT, BFBR_SIGNED_EXTRACT,
    BFBR_UNSIGNED_EXTRACT, BFBR_SIGN_WIDEN_BYTE, BFBR_ZERO_WIDEN_BYTE,
    BFBR_SIGN_WIDEN_HALF, BFBR_ZERO_WIDEN_HALF, BFBR_REL_JUMP, BFBR_CALL_REL_JUMP,
    BFBR_REG_JUMP, BFBR_REG_CALL, BFBR_ZERO_TEST_JUMP, BFBR_NONZERO_TEST_JUMP
  } bfbr_op_t;
  localparam int unsigned DATA_W = 32;
  localparam logic [3:0] RETURN_ADDR_IDX = 4'hE;
  localparam logic [3:0] COND_ALWAYS = 4'hE;
  localparam logic [31:0] INSTR_STEP = 32'h0000_0004;
  // Relative offset limits in bytes: one and sixteen megabytes.
  localparam logic signed [31:0] RANGE_NEAR = 32'sh0010_0000;
  localparam logic signed [31:0] RANGE_FAR = 32'sh0100_0000;
  localparam logic [4:0] ROT_STEP_BITS = 5'h08;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned HALF_W = 16;
  // Most instructions one conditional block can cover.
  localparam logic [2:0] BLOCK_MAX = 3'h4;
endpackage

// ---- verification/bfbr_fetch_model.sv ----
// Fetch-side model: holds the current instruction address for the unit.
// Assumes the unit reports taken jumps one cycle after the operation.
`timescale 1ns/1ps
module bfbr_fetch_model (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic pc_load_in,
  input wire logic [31:0] pc_target_in,
  output logic [31:0] pc_out
);
  // The address moves only on a taken jump, so the bench can predict it.
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      pc_out <= 32'h0000_2000;
    end else if (pc_load_in) begin
      pc_out <= pc_target_in;
    end
  end
endmodule

// ---- verification/bfbr_exec_tb.sv ----
// Self-checking bench for the bitfield and jump unit.
// Assumes one-cycle answers after the taking edge, as the unit promises.
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_errors++; \
  $display("FAIL %0t mismatch", $time); end end
module bfbr_exec_tb;
  logic clk = 0, rst_n = 0, v = 0, bs = 0, we, link_we, pcl, mf, re;
  bfbr_pkg::bfbr_op_t op = bfbr_pkg::BFBR_NOP;
  logic [3:0] cond = 4'hE, bmask = 4'h1, fl = 4'h4, idx, flo;
  logic [2:0] blen = 3'h1;
  logic [31:0] dv = 32'h0, sv = 32'h0, off = 32'h0, pc, wd, rd, pct;
  logic [4:0] pos = 5'h00;
  logic [5:0] wid = 6'h01;
  logic [1:0] rot = 2'h0;
  int n_errors = 0, samples_checked = 0, cyc = 0;
  bfbr_exec uut (.clock_in(clk), .rst_n_in(rst_n), .op_valid_in(v), .op_in(op), .cond_in(cond),
    .block_start_in(bs), .block_len_in(blen), .block_then_mask_in(bmask), .flags_in(fl),
    .dest_val_in(dv), .first_src_in(sv), .operand_in(sv), .field_low_pos_in(pos),
    .field_width_in(wid), .rotate_sel_in(rot), .pc_in(pc), .rel_offset_in(off),
    .wr_en_out(we), .wr_data_out(wd), .ret_wr_en_out(link_we), .ret_data_out(rd),
    .ret_idx_out(idx), .pc_load_out(pcl), .pc_target_out(pct), .misuse_fault_out(mf),
    .range_err_out(re), .flags_out(flo));
  bfbr_fetch_model fetch (.clock_in(clk), .rst_n_in(rst_n), .pc_load_in(pcl),
    .pc_target_in(pct), .pc_out(pc));
  // Free-running 200 MHz clock.
  initial begin
    forever #2.5 clk = ~clk;
  end
  // Prints the counts and the verdict, then stops.
  task end_sim;
    $display("Checked %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Presents one operation, waits for its taking edge, then lets outputs settle.
  task run(input bfbr_pkg::bfbr_op_t o, input logic [3:0] c, input logic [31:0] d, s,
           input logic [4:0] p, input logic [5:0] w, input logic [1:0] r, input logic [31:0] f);
    @(posedge clk);
    op <= o; cond <= c; dv <= d; sv <= s; pos <= p; wid <= w; rot <= r; off <= f; v <= 1;
    @(posedge clk);
    v <= 0;
    #1;
  endtask
  // Field clear, insert at the top bit, signed and unsigned extract.
  task t_field;
    run(bfbr_pkg::BFBR_FIELD_CLEAR, 4'hE, 32'hFFFFFFFF, 0, 5'h08, 6'h0C, 0, 0);
    `CHK(wd, 32'hFFF000FF)
    `CHK(flo, fl)
    run(bfbr_pkg::BFBR_FIELD_INSERT, 4'hE, 32'h0, 32'h00000003, 5'h1F, 6'h01, 0, 0);
    `CHK(wd, 32'h80000000)
    run(bfbr_pkg::BFBR_SIGNED_EXTRACT, 4'hE, 0, 32'h00800000, 5'h14, 6'h04, 0, 0);
    `CHK(wd, 32'hFFFFFFF8)
    run(bfbr_pkg::BFBR_UNSIGNED_EXTRACT, 4'hE, 0, 32'hFFFFFFFF, 5'h09, 6'h0A, 0, 0);
    `CHK(wd, 32'h000003FF)
  endtask
  // Every widening form, each with a different rotate amount.
  task t_widen;
    bfbr_pkg::bfbr_op_t wo[4];
    logic [31:0] we_x[4];
    wo = '{bfbr_pkg::BFBR_SIGN_WIDEN_BYTE, bfbr_pkg::BFBR_ZERO_WIDEN_HALF,
           bfbr_pkg::BFBR_ZERO_WIDEN_BYTE, bfbr_pkg::BFBR_SIGN_WIDEN_HALF};
    we_x = '{32'h00000001, 32'h0000FF7F, 32'h000000FF, 32'h00000180};
    for (int i = 0; i < 4; i++) begin
      run(wo[i], 4'hE, 0, 32'h80FF7F01, 0, 0, i[1:0], 0);
      `CHK(wd, we_x[i])
    end
    run(bfbr_pkg::BFBR_SIGN_WIDEN_BYTE, 4'hE, 0, 32'h80FF7F01, 0, 0, 2'h3, 0);
    `CHK(wd, 32'hFFFFFF80)
  endtask
  // Register call links and clears bit zero; a clear bit zero faults instead.
  task t_reg;
    run(bfbr_pkg::BFBR_REG_CALL, 4'hE, 0, 32'h00001001, 0, 0, 0, 0);
    `CHK({pcl, link_we, idx}, 6'h3E)
    `CHK(rd, pc + 32'h4)
    `CHK(pct, 32'h00001000)
    run(bfbr_pkg::BFBR_CALL_REL_JUMP, 4'hE, 0, 0, 0, 0, 0, 32'h00000100);
    `CHK(link_we, 1'b1)
    run(bfbr_pkg::BFBR_REG_JUMP, 4'hE, 0, 32'h00002000, 0, 0, 0, 0);
    `CHK({mf, pcl}, 2'h2)
    run(bfbr_pkg::BFBR_REG_JUMP, 4'hE, 0, 32'h00003003, 0, 0, 0, 0);
    `CHK({mf, pcl, link_we, pct}, {3'h2, 32'h00003002})
  endtask
  // Near offset limit at both ends, far reach past the near limit, and a failed condition outside a block.
  task t_range;
    run(bfbr_pkg::BFBR_REL_JUMP, 4'h0, 0, 0, 0, 0, 0, 32'h00100000);
    `CHK({re, pcl}, 2'h2)
    run(bfbr_pkg::BFBR_REL_JUMP, 4'h0, 0, 0, 0, 0, 0, 32'hFFF00000);
    `CHK({re, pcl}, 2'h1)
    run(bfbr_pkg::BFBR_REL_JUMP, 4'hE, 0, 0, 0, 0, 0, 32'h00100000);
    `CHK({re, pcl}, 2'h1)
    run(bfbr_pkg::BFBR_REL_JUMP, 4'h1, 0, 0, 0, 0, 0, 32'h00000040);
    `CHK(pcl, 1'b0)
    `CHK(flo, fl)
  endtask
  // Zero and nonzero tests, each with a zero and a nonzero operand.
  task t_test;
    run(bfbr_pkg::BFBR_ZERO_TEST_JUMP, 4'hE, 0, 0, 0, 0, 0, 32'h4);
    `CHK(pcl, 1'b1)
    run(bfbr_pkg::BFBR_ZERO_TEST_JUMP, 4'hE, 0, 32'h5, 0, 0, 0, 32'h82);
    `CHK(pcl, 1'b0)
    run(bfbr_pkg::BFBR_NONZERO_TEST_JUMP, 4'hE, 0, 0, 0, 0, 0, 32'h82);
    `CHK(pcl, 1'b0)
    run(bfbr_pkg::BFBR_NONZERO_TEST_JUMP, 4'hE, 0, 32'h5, 0, 0, 0, 32'h4);
    `CHK({pcl, flo}, {1'b1, fl})
  endtask
  // A two-slot block: then slot runs with Z set, else slot is suppressed.
  task t_block;
    @(posedge clk);
    bs <= 1; cond <= 4'h0; blen <= 3'h2; bmask <= 4'h1;
    @(posedge clk);
    bs <= 0;
    run(bfbr_pkg::BFBR_FIELD_CLEAR, 4'h0, 32'hFFFFFFFF, 0, 0, 6'h04, 0, 0);
    `CHK({we, wd}, {1'b1, 32'hFFFFFFF0})
    run(bfbr_pkg::BFBR_FIELD_CLEAR, 4'h1, 32'hFFFFFFFF, 0, 0, 6'h04, 0, 0);
    `CHK(we, 1'b0)
  endtask
  // Cuts a hang short.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_errors++;
      end_sim;
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    #1;
    `CHK({we, pcl, mf, re}, 4'h0)
    @(posedge clk);
    rst_n <= 1;
    t_field;
    t_widen;
    t_reg;
    t_range;
    t_test;
    t_block;
    end_sim;
  end
endmodule
